/* hdl/rifc_pkg.sv */
package rifc_pkg;
  // register port offsets
  localparam logic [6:0] RIFC_ADDR_STATUS_FIRST = 7'h03;
  localparam logic [6:0] RIFC_ADDR_STATUS_SECOND = 7'h04;
  localparam logic [6:0] RIFC_ADDR_ENABLE_FIRST = 7'h05;
  localparam logic [6:0] RIFC_ADDR_ENABLE_SECOND = 7'h06;
  localparam logic [6:0] RIFC_ADDR_OFFSET_LOW = 7'h73;
  localparam logic [6:0] RIFC_ADDR_OFFSET_HIGH = 7'h74;
  localparam logic [6:0] RIFC_ADDR_BAND_SELECT = 7'h75;
  localparam logic [6:0] RIFC_ADDR_FRACTION_HIGH = 7'h76;
  localparam logic [6:0] RIFC_ADDR_FRACTION_LOW = 7'h77;
  // values after reset
  localparam logic [7:0] RIFC_RST_STATUS = 8'h00;
  localparam logic [7:0] RIFC_RST_ENABLE_FIRST = 8'h00;
  localparam logic [7:0] RIFC_RST_ENABLE_SECOND = 8'h01;
  localparam logic [7:0] RIFC_RST_OFFSET_LOW = 8'h00;
  localparam logic [1:0] RIFC_RST_OFFSET_HIGH = 2'h0;
  localparam logic [7:0] RIFC_RST_BAND_SELECT = 8'h35;
  localparam logic [7:0] RIFC_RST_FRACTION_HIGH = 8'hBB;
  localparam logic [7:0] RIFC_RST_FRACTION_LOW = 8'h80;
  // field positions
  localparam int RIFC_BAND_SIDE_BIT = 6;
  localparam int RIFC_BAND_HIGH_BIT = 5;
  localparam int RIFC_STATUS_POWER_ON_BIT = 0;
  localparam int RIFC_STATUS_CHIP_READY_BIT = 1;
  // synthesizer arithmetic
  localparam logic [4:0] RIFC_BAND_INT_MAX = 5'h17;
  localparam logic [6:0] RIFC_INT_OFFSET = 7'h18;
  localparam logic signed [19:0] RIFC_FRAC_MOD = 20'sh0FA00;
  localparam logic signed [19:0] RIFC_FRAC_MOD_TWICE = 20'sh1F400;
  // sequencer timing
  localparam int RIFC_CLK_PERIOD_NS = 100;
  localparam int RIFC_BIAS_SETTLE_US = 50;
  localparam int RIFC_VCO_CAL_US = 50;
  localparam int RIFC_SYNTH_SETTLE_US = 100;
  localparam int RIFC_TOTAL_BUDGET_US = 200;
  localparam logic [10:0] RIFC_BIAS_CYCLES =
    11'((RIFC_BIAS_SETTLE_US * 1000 + RIFC_CLK_PERIOD_NS - 1) / RIFC_CLK_PERIOD_NS);
  localparam logic [10:0] RIFC_CAL_CYCLES =
    11'((RIFC_VCO_CAL_US * 1000 + RIFC_CLK_PERIOD_NS - 1) / RIFC_CLK_PERIOD_NS);
  localparam logic [10:0] RIFC_SETTLE_CYCLES =
    11'((RIFC_SYNTH_SETTLE_US * 1000 + RIFC_CLK_PERIOD_NS - 1) / RIFC_CLK_PERIOD_NS);
  localparam logic [10:0] RIFC_BUDGET_CYCLES =
    11'((RIFC_TOTAL_BUDGET_US * 1000) / RIFC_CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    RIFC_SEQ_IDLE = 3'h0,
    RIFC_SEQ_BIAS = 3'h1,
    RIFC_SEQ_CAL = 3'h3,
    RIFC_SEQ_SETTLE = 3'h2,
    RIFC_SEQ_ACTIVE = 3'h6
  } rifc_seq_state_t;

  typedef enum logic [1:0] {
    RIFC_MODE_READY = 2'h0,
    RIFC_MODE_TUNE = 2'h1,
    RIFC_MODE_TX = 2'h3,
    RIFC_MODE_RX = 2'h2
  } rifc_mode_t;
endpackage

/* hdl/rifc_event_bank.sv */
`timescale 1ns/1ps
module rifc_event_bank import rifc_pkg::*; #(
  parameter logic [7:0] ENABLE_RESET = 8'h00
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] event_in,
  input wire logic read_clear_in,
  input wire logic enable_write_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] status_out,
  output logic [7:0] enable_out
);
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] enable;
  } rifc_bank_state_t;

  rifc_bank_state_t cur_reg;
  rifc_bank_state_t cur_next;
  logic [7:0] status_bit_next;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      // a new event wins over the clear of the same cycle
      assign status_bit_next[gi] = event_in[gi] |
        (cur_reg.status[gi] & ~(read_clear_in & cur_reg.enable[gi]));
    end
  endgenerate

  always_comb begin
    cur_next = cur_reg;
    cur_next.status = status_bit_next;
    if (enable_write_in) begin
      cur_next.enable = wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cur_reg.status <= RIFC_RST_STATUS;
      cur_reg.enable <= ENABLE_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign status_out = cur_reg.status;
  assign enable_out = cur_reg.enable;
endmodule // rifc_event_bank

/* hdl/rifc_synth_seq.sv */
`timescale 1ns/1ps
module rifc_synth_seq import rifc_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic synth_needed_in,
  input wire logic freq_change_in,
  output rifc_seq_state_t state_out,
  output logic vco_cal_out,
  output logic synth_en_out,
  output logic chip_ready_out
);
  typedef struct packed {
    rifc_seq_state_t state;
    logic [10:0] count;
    logic powerup;
    logic cal;
    logic en;
    logic ready;
  } rifc_seq_reg_t;

  rifc_seq_reg_t cur_reg;
  rifc_seq_reg_t cur_next;

  always_comb begin
    cur_next = cur_reg;
    cur_next.ready = 1'b0;
    case (cur_reg.state)
      RIFC_SEQ_IDLE: begin
        if (synth_needed_in) begin
          cur_next.state = RIFC_SEQ_BIAS;
          cur_next.count = RIFC_BIAS_CYCLES - 11'h001;
        end
      end
      RIFC_SEQ_BIAS: begin
        if (cur_reg.count == 11'h000) begin
          cur_next.state = RIFC_SEQ_CAL;
          cur_next.count = RIFC_CAL_CYCLES - 11'h001;
        end else begin
          cur_next.count = cur_reg.count - 11'h001;
        end
      end
      RIFC_SEQ_CAL: begin
        if (cur_reg.count == 11'h000) begin
          cur_next.state = RIFC_SEQ_SETTLE;
          cur_next.count = RIFC_SETTLE_CYCLES - 11'h001;
        end else begin
          cur_next.count = cur_reg.count - 11'h001;
        end
      end
      RIFC_SEQ_SETTLE: begin
        if (cur_reg.count == 11'h000) begin
          cur_next.state = synth_needed_in ? RIFC_SEQ_ACTIVE : RIFC_SEQ_IDLE;
          cur_next.ready = cur_reg.powerup;
          cur_next.powerup = 1'b0;
        end else begin
          cur_next.count = cur_reg.count - 11'h001;
        end
      end
      RIFC_SEQ_ACTIVE: begin
        if (!synth_needed_in) begin
          cur_next.state = RIFC_SEQ_IDLE;
        end
      end
      default: begin
        cur_next.state = RIFC_SEQ_IDLE;
      end
    endcase
    // a retune in cal, settle or active skips bias settling and recalibrates; bias goes to cal anyway, idle ignores it
    if (freq_change_in && (cur_reg.state inside {RIFC_SEQ_CAL, RIFC_SEQ_SETTLE,
        RIFC_SEQ_ACTIVE})) begin
      cur_next.state = RIFC_SEQ_CAL;
      cur_next.count = RIFC_CAL_CYCLES - 11'h001;
    end
    cur_next.cal = (cur_next.state == RIFC_SEQ_CAL);
    cur_next.en = (cur_next.state != RIFC_SEQ_IDLE);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cur_reg.state <= RIFC_SEQ_BIAS;
      cur_reg.count <= RIFC_BIAS_CYCLES - 11'h001;
      cur_reg.powerup <= 1'b1;
      cur_reg.cal <= 1'b0;
      cur_reg.en <= 1'b1;
      cur_reg.ready <= 1'b0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign state_out = cur_reg.state;
  assign vco_cal_out = cur_reg.cal;
  assign synth_en_out = cur_reg.en;
  assign chip_ready_out = cur_reg.ready;
endmodule // rifc_synth_seq

/* hdl/rifc_top.sv */
// Overview of operation
// - interrupt output goes low whenever any enabled event is pending.
// - all enabled status sources are ORed into the single interrupt output.
// - interrupt stays low until host reads the status register holding the bit.
// - after that read the interrupt releases until a new event arrives.
// - only events with their enable bit set can drive the interrupt.
// - reading a status register clears its bits whose enable is set.
// - disabled events still set readable status bits but never drive the interrupt.
// - power-on indication is shown on general pins zero and one.
// - once the first interrupt is cleared the interrupt works normally.
// - host writes a target mode; sequencer walks every step itself.
// - oscillator calibration starts on every power-up and on every frequency change except while the sequencer is idle.
// - synthesizer settling interval lasts 100 microseconds.
// - bias settle, calibration and synth settle together take 200 microseconds.
// - fractional modulator accumulators wrap at modulo 64000.
// - carrier is 10 MHz times band factor times (integer + 24 + fraction/64000).
// - high band select drives an outside divide-by-two; zero means low band.
// - band integer select holds 0 to 23; larger writes store 23.
// - each integer step is 10 MHz low band or 20 MHz high band.
// - fraction combines carrier fraction, offset and deviation keyed by data.
// - after power-on reset the device settles in ready idle.
`timescale 1ns/1ps
module rifc_top import rifc_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [7:0] event_first_in,
  input wire logic [7:0] event_second_in,
  input wire logic [1:0] mode_target_in,
  input wire logic fsk_data_in,
  input wire logic [8:0] deviation_word_in,
  output logic irq_out_n,
  output logic general_pin_zero_out,
  output logic general_pin_one_out,
  output logic [6:0] synth_int_out,
  output logic high_band_out,
  output rifc_seq_state_t seq_state_out,
  output logic vco_cal_out,
  output logic synth_en_out,
  output logic [1:0] mode_active_out
);
  typedef struct packed {
    logic [7:0] rdata;
    logic irq_n;
    logic pin_zero;
    logic pin_one;
    logic por_pending;
    logic [7:0] off_low;
    logic [1:0] off_high;
    logic side_sel;
    logic high_band;
    logic [4:0] band_int;
    logic [15:0] fraction;
    logic [6:0] synth_int;
    logic hb_out;
    logic [15:0] acc;
    logic [1:0] mode_act;
  } rifc_top_reg_t;

  rifc_top_reg_t cur_reg;
  rifc_top_reg_t cur_next;

  logic [7:0] status_first;
  logic [7:0] status_second;
  logic [7:0] enable_first;
  logic [7:0] enable_second;
  logic [7:0] event_second_all;
  logic chip_ready;
  logic freq_change;
  logic synth_needed;
  logic rd_first;
  logic rd_second;
  logic pending;
  logic signed [19:0] frac_sum;
  logic signed [19:0] dev_scaled;
  logic signed [19:0] acc_sum;
  logic [6:0] int_base;

  assign rd_first = reg_rd_in && (reg_addr_in == RIFC_ADDR_STATUS_FIRST);
  assign rd_second = reg_rd_in && (reg_addr_in == RIFC_ADDR_STATUS_SECOND);
  assign freq_change = reg_wr_in && (reg_addr_in inside {RIFC_ADDR_OFFSET_LOW,
    RIFC_ADDR_OFFSET_HIGH, RIFC_ADDR_BAND_SELECT, RIFC_ADDR_FRACTION_HIGH,
    RIFC_ADDR_FRACTION_LOW});
  assign synth_needed = (mode_target_in != RIFC_MODE_READY);

  // power-on and chip-ready are raised inside, on top of whatever the radio reports
  always_comb begin
    event_second_all = event_second_in;
    event_second_all[RIFC_STATUS_POWER_ON_BIT] = event_second_in[RIFC_STATUS_POWER_ON_BIT] |
      cur_reg.por_pending;
    event_second_all[RIFC_STATUS_CHIP_READY_BIT] =
      event_second_in[RIFC_STATUS_CHIP_READY_BIT] | chip_ready;
  end

  rifc_event_bank #(.ENABLE_RESET(RIFC_RST_ENABLE_FIRST)) u_bank_first (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .event_in(event_first_in),
    .read_clear_in(rd_first),
    .enable_write_in(reg_wr_in && (reg_addr_in == RIFC_ADDR_ENABLE_FIRST)),
    .wdata_in(reg_wdata_in),
    .status_out(status_first),
    .enable_out(enable_first)
  );

  rifc_event_bank #(.ENABLE_RESET(RIFC_RST_ENABLE_SECOND)) u_bank_second (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .event_in(event_second_all),
    .read_clear_in(rd_second),
    .enable_write_in(reg_wr_in && (reg_addr_in == RIFC_ADDR_ENABLE_SECOND)),
    .wdata_in(reg_wdata_in),
    .status_out(status_second),
    .enable_out(enable_second)
  );

  rifc_synth_seq u_seq (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .synth_needed_in(synth_needed),
    .freq_change_in(freq_change),
    .state_out(seq_state_out),
    .vco_cal_out(vco_cal_out),
    .synth_en_out(synth_en_out),
    .chip_ready_out(chip_ready)
  );

  assign pending = |(status_first & enable_first) | |(status_second & enable_second);

  // deviation steps are 625 Hz in both bands, i.e. 4 or 2 fraction steps
  always_comb begin
    dev_scaled = cur_reg.high_band ? $signed({10'h000, deviation_word_in, 1'b0})
                                   : $signed({9'h000, deviation_word_in, 2'h0});
    if (cur_reg.mode_act != RIFC_MODE_TX) begin
      dev_scaled = 20'sh00000;
    end else if (!fsk_data_in) begin
      dev_scaled = -dev_scaled;
    end
    frac_sum = $signed({4'h0, cur_reg.fraction}) +
      $signed({{10{cur_reg.off_high[1]}}, cur_reg.off_high, cur_reg.off_low}) +
      dev_scaled;
    acc_sum = $signed({4'h0, cur_reg.acc}) + frac_sum;
    int_base = {2'h0, cur_reg.band_int} + RIFC_INT_OFFSET;
  end

  always_comb begin
    cur_next = cur_reg;
    cur_next.por_pending = 1'b0;
    cur_next.irq_n = ~pending;
    cur_next.pin_zero = status_second[RIFC_STATUS_POWER_ON_BIT];
    cur_next.pin_one = status_second[RIFC_STATUS_POWER_ON_BIT];
    cur_next.mode_act = (seq_state_out == RIFC_SEQ_ACTIVE) ? mode_target_in
                                                           : RIFC_MODE_READY;
    cur_next.hb_out = cur_reg.high_band;
    // carry out of the wrap steps the divider by whole units
    if (acc_sum >= RIFC_FRAC_MOD_TWICE) begin
      cur_next.acc = 16'(acc_sum - RIFC_FRAC_MOD_TWICE);
      cur_next.synth_int = int_base + 7'h02;
    end else if (acc_sum >= RIFC_FRAC_MOD) begin
      cur_next.acc = 16'(acc_sum - RIFC_FRAC_MOD);
      cur_next.synth_int = int_base + 7'h01;
    end else if (acc_sum < 20'sh00000) begin
      cur_next.acc = 16'(acc_sum + RIFC_FRAC_MOD);
      cur_next.synth_int = int_base - 7'h01;
    end else begin
      cur_next.acc = 16'(acc_sum);
      cur_next.synth_int = int_base;
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        RIFC_ADDR_OFFSET_LOW: begin
          cur_next.off_low = reg_wdata_in;
        end
        RIFC_ADDR_OFFSET_HIGH: begin
          cur_next.off_high = reg_wdata_in[1:0];
        end
        RIFC_ADDR_BAND_SELECT: begin
          cur_next.side_sel = reg_wdata_in[RIFC_BAND_SIDE_BIT];
          cur_next.high_band = reg_wdata_in[RIFC_BAND_HIGH_BIT];
          cur_next.band_int = (reg_wdata_in[4:0] > RIFC_BAND_INT_MAX) ? RIFC_BAND_INT_MAX
                                                                      : reg_wdata_in[4:0];
        end
        RIFC_ADDR_FRACTION_HIGH: begin
          cur_next.fraction[15:8] = reg_wdata_in;
        end
        RIFC_ADDR_FRACTION_LOW: begin
          cur_next.fraction[7:0] = reg_wdata_in;
        end
        default: begin
          cur_next.fraction = cur_reg.fraction;
        end
      endcase
    end
    cur_next.rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        RIFC_ADDR_STATUS_FIRST: cur_next.rdata = status_first;
        RIFC_ADDR_STATUS_SECOND: cur_next.rdata = status_second;
        RIFC_ADDR_ENABLE_FIRST: cur_next.rdata = enable_first;
        RIFC_ADDR_ENABLE_SECOND: cur_next.rdata = enable_second;
        RIFC_ADDR_OFFSET_LOW: cur_next.rdata = cur_reg.off_low;
        RIFC_ADDR_OFFSET_HIGH: cur_next.rdata = {6'h00, cur_reg.off_high};
        RIFC_ADDR_BAND_SELECT: begin
          cur_next.rdata = {1'b0, cur_reg.side_sel, cur_reg.high_band, cur_reg.band_int};
        end
        RIFC_ADDR_FRACTION_HIGH: cur_next.rdata = cur_reg.fraction[15:8];
        RIFC_ADDR_FRACTION_LOW: cur_next.rdata = cur_reg.fraction[7:0];
        default: cur_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cur_reg.rdata <= 8'h00;
      cur_reg.irq_n <= 1'b1;
      cur_reg.pin_zero <= 1'b0;
      cur_reg.pin_one <= 1'b0;
      cur_reg.por_pending <= 1'b1;
      cur_reg.off_low <= RIFC_RST_OFFSET_LOW;
      cur_reg.off_high <= RIFC_RST_OFFSET_HIGH;
      cur_reg.side_sel <= RIFC_RST_BAND_SELECT[RIFC_BAND_SIDE_BIT];
      cur_reg.high_band <= RIFC_RST_BAND_SELECT[RIFC_BAND_HIGH_BIT];
      cur_reg.band_int <= RIFC_RST_BAND_SELECT[4:0];
      cur_reg.fraction <= {RIFC_RST_FRACTION_HIGH, RIFC_RST_FRACTION_LOW};
      cur_reg.synth_int <= RIFC_INT_OFFSET;
      cur_reg.hb_out <= 1'b0;
      cur_reg.acc <= 16'h0000;
      cur_reg.mode_act <= RIFC_MODE_READY;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign reg_rdata_out = cur_reg.rdata;
  assign irq_out_n = cur_reg.irq_n;
  assign general_pin_zero_out = cur_reg.pin_zero;
  assign general_pin_one_out = cur_reg.pin_one;
  assign synth_int_out = cur_reg.synth_int;
  assign high_band_out = cur_reg.hb_out;
  assign mode_active_out = cur_reg.mode_act;

  // helper counters seen only by the checks below
  logic [10:0] settle_run_reg;
  logic [11:0] busy_run_reg;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      settle_run_reg <= 11'h000;
      busy_run_reg <= 12'h000;
    end else begin
      settle_run_reg <= (seq_state_out == RIFC_SEQ_SETTLE) ? settle_run_reg + 11'h001 : 11'h000;
      busy_run_reg <= (seq_state_out inside {RIFC_SEQ_BIAS, RIFC_SEQ_CAL, RIFC_SEQ_SETTLE})
        ? busy_run_reg + 12'h001 : 12'h000;
    end
  end

  sequence freq_write_s;
    freq_change && (seq_state_out inside {RIFC_SEQ_CAL, RIFC_SEQ_SETTLE, RIFC_SEQ_ACTIVE});
  endsequence
  sequence cal_started_s;
    ##1 (seq_state_out == RIFC_SEQ_CAL) ##1 vco_cal_out;
  endsequence

  AST_IRQ_ASSERTED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    pending |=> !irq_out_n) else $error("interrupt not driven low for pending event");
  AST_IRQ_RELEASED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !pending |=> irq_out_n) else $error("interrupt low with nothing enabled pending");
  AST_CLEAR_ON_READ: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (rd_first && event_first_in == 8'h00) |=> ((status_first & $past(enable_first)) == 8'h00))
    else $error("enabled status bits survived a status read");
  // only the disabled bits are followed, so this holds with any enable pattern
  AST_DISABLED_KEPT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    rd_first |=> ((status_first & $past(status_first) & ~$past(enable_first)) ==
    ($past(status_first) & ~$past(enable_first)))) else $error("disabled status bit lost on read");
  AST_EVENT_NOT_LOST: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (rd_first && (event_first_in & enable_first) != 8'h00) |=> ##1 !irq_out_n)
    else $error("event during status read did not reassert interrupt");
  AST_POWER_ON_PINS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    status_second[RIFC_STATUS_POWER_ON_BIT] |=> (general_pin_zero_out && general_pin_one_out))
    else $error("power-on indication missing on general pins");
  AST_BAND_CLAMP: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == RIFC_ADDR_BAND_SELECT && reg_wdata_in[4:0] > 5'h17)
    |=> (cur_reg.band_int == 5'h17)) else $error("band integer not held at 23");
  AST_SETTLE_LENGTH: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ($past(seq_state_out) == RIFC_SEQ_SETTLE && seq_state_out inside {RIFC_SEQ_ACTIVE,
    RIFC_SEQ_IDLE}) |-> (settle_run_reg == RIFC_SETTLE_CYCLES))
    else $error("settle interval not 100 us");
  AST_BUDGET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    busy_run_reg <= RIFC_BUDGET_CYCLES) else $error("calibration sequence overran 200 us");
  AST_CAL_ON_RETUNE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    freq_write_s |-> cal_started_s) else $error("frequency change did not start calibration");
  AST_ACC_WRAP: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cur_reg.acc < 16'hFA00) else $error("fraction accumulator above modulus");
  // the divider word resets to RIFC_INT_OFFSET alone, not band word plus 24, so skip that first edge
  AST_INT_OFFSET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !$past(rst_in) |->
    (synth_int_out >= $past(int_base) - 7'h01) && (synth_int_out <= $past(int_base) + 7'h02))
    else $error("divider integer not band integer plus 24");
endmodule // rifc_top

/* sim/rifc_host_model.sv */
`timescale 1ns/1ps
module rifc_host_model (
  input wire logic clk_sys_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [6:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out
);
  initial begin
    reg_addr_out = 7'h7F;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'hFF;
  end
  // one strobe cycle; the idle gap after it keeps a strobe from being driven twice in a step
  task automatic access(input logic [6:0] addr, input logic wr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    @(negedge clk_sys_in);
    reg_addr_out = addr;
    reg_wdata_out = wdata;
    reg_wr_out = wr;
    reg_rd_out = !wr;
    @(negedge clk_sys_in);
    rdata = reg_rdata_in;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    // released lines show the inverse so a stale value never looks held
    reg_addr_out = ~addr;
    reg_wdata_out = ~wdata;
  endtask
  // chip-ready is found by polling status, never through the interrupt pin
  task automatic poll_ready(input int limit, output logic ok);
    logic [7:0] rd;
    ok = 1'b0;
    for (int i = 0; i < limit && !ok; i++) begin
      access(7'h04, 1'b0, 8'h00, rd);
      ok = (rd[1] === 1'b1);
    end
  endtask
endmodule // rifc_host_model

/* sim/rifc_top_tb_top.sv */
`timescale 1ns/1ps
module rifc_top_tb_top;
  import rifc_pkg::*;
  typedef struct packed {logic [6:0] addr; logic wr; logic [7:0] wd; logic [7:0] exp;} rifc_row_t;
  logic clk_sys_in, rst_in, reg_wr, reg_rd, irq_n, pin0, pin1, hb, cal, ok, fsk, sen;
  logic [8:0] dev;
  logic [6:0] reg_addr, sint;
  logic [7:0] reg_wdata, reg_rdata, ev1, ev2, rd;
  logic [1:0] mode_tgt, mact;
  rifc_seq_state_t st;
  int err_count, checks_done, n, ncal, nset;
  rifc_row_t rows [16] = '{'{7'h05, 0, 0, 8'h00}, '{7'h06, 0, 0, 8'h01}, '{7'h73, 0, 0, 8'h00},
    '{7'h74, 0, 0, 8'h00}, '{7'h75, 0, 0, 8'h35}, '{7'h76, 0, 0, 8'hBB}, '{7'h77, 0, 0, 8'h80},
    '{7'h10, 0, 0, 8'h00}, '{7'h74, 1, 8'hFF, 8'h03}, '{7'h75, 1, 8'hFF, 8'h77},
    '{7'h76, 1, 0, 8'h00}, '{7'h77, 1, 0, 8'h00}, '{7'h74, 1, 0, 8'h00},
    '{7'h10, 1, 8'hFF, 8'h00}, '{7'h05, 1, 8'h08, 8'h08}, '{7'h06, 1, 8'h11, 8'h11}};
  rifc_top dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .event_first_in(ev1), .event_second_in(ev2), .mode_target_in(mode_tgt), .fsk_data_in(fsk),
    .deviation_word_in(dev), .irq_out_n(irq_n), .general_pin_zero_out(pin0),
    .general_pin_one_out(pin1), .synth_int_out(sint), .high_band_out(hb), .seq_state_out(st),
    .vco_cal_out(cal), .synth_en_out(sen), .mode_active_out(mact));
  rifc_host_model host_u (.clk_sys_in(clk_sys_in), .reg_rdata_in(reg_rdata),
    .reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_wdata_out(reg_wdata));
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_val(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic pulse(input logic [7:0] e1, input logic [7:0] e2);
    @(negedge clk_sys_in);
    ev1 = e1;
    ev2 = e2;
    @(negedge clk_sys_in);
    ev1 = 8'h00;
    ev2 = 8'h00;
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (15000) @(posedge clk_sys_in);
    err_count++;
    give_verdict();
  end
  initial begin
    rst_in = 1'b1;
    ev1 = 8'h00;
    ev2 = 8'h00;
    mode_tgt = 2'h0;
    fsk = 1'b0;
    dev = 9'h000;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    chk_bit("por_irq_n", 1'b0, irq_n);
    chk_bit("pin_zero", 1'b1, pin0);
    chk_bit("pin_one", 1'b1, pin1);
    foreach (rows[i]) begin
      if (rows[i].wr) host_u.access(rows[i].addr, 1'b1, rows[i].wd, rd);
      host_u.access(rows[i].addr, 1'b0, 8'h00, rd);
      chk_val("reg", {24'h0, rows[i].exp}, {24'h0, rd});
    end
    chk_val("synth_int_top", 32'd47, {25'h0, sint});
    chk_bit("high_band", 1'b1, hb);
    host_u.access(7'h75, 1'b1, 8'h40, rd);
    repeat (3) @(negedge clk_sys_in);
    chk_val("synth_int_low", 32'd24, {25'h0, sint});
    chk_bit("low_band", 1'b0, hb);
    host_u.poll_ready(2000, ok);
    repeat (2) @(negedge clk_sys_in);
    chk_bit("chip_ready", 1'b1, ok);
    chk_bit("pin_clear", 1'b0, pin0);
    chk_bit("irq_after_por", 1'b1, irq_n);
    mode_tgt = 2'h1;
    for (int i = 0; i < 10 && st !== RIFC_SEQ_BIAS; i++) @(negedge clk_sys_in);
    n = 0;
    ncal = 0;
    nset = 0;
    // cycles in bias, cal and settle are counted from the first bias cycle
    while (st !== RIFC_SEQ_ACTIVE && n < 3000) begin
      ncal += int'(cal === 1'b1);
      nset += int'(st === RIFC_SEQ_SETTLE);
      n++;
      @(negedge clk_sys_in);
    end
    chk_val("budget", 32'd2000, n);
    chk_val("cal_len", 32'd500, ncal);
    chk_val("settle_len", 32'd1000, nset);
    @(negedge clk_sys_in);
    chk_val("mode_active", 32'h1, {30'h0, mact});
    host_u.access(7'h77, 1'b1, 8'h00, rd);
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk_sys_in);
      ok = (cal === 1'b1);
    end
    chk_bit("recal", 1'b1, ok);
    pulse(8'h04, 8'h00);
    repeat (3) @(negedge clk_sys_in);
    chk_bit("irq_disabled", 1'b1, irq_n);
    pulse(8'h08, 8'h00);
    @(negedge clk_sys_in);
    chk_bit("irq_set", 1'b0, irq_n);
    host_u.access(7'h03, 1'b0, 8'h00, rd);
    chk_val("status1", 32'h0C, {24'h0, rd});
    repeat (2) @(negedge clk_sys_in);
    chk_bit("irq_release", 1'b1, irq_n);
    host_u.access(7'h03, 1'b0, 8'h00, rd);
    chk_val("status1_kept", 32'h04, {24'h0, rd});
    pulse(8'h00, 8'h10);
    @(negedge clk_sys_in);
    chk_bit("irq_second", 1'b0, irq_n);
    host_u.access(7'h04, 1'b0, 8'h00, rd);
    chk_val("status2", 32'h12, {24'h0, rd});
    // the event lands on the very edge that takes the read
    fork
      host_u.access(7'h03, 1'b0, 8'h00, rd);
      pulse(8'h08, 8'h00);
    join
    chk_val("status_race", 32'h04, {24'h0, rd});
    repeat (2) @(negedge clk_sys_in);
    chk_bit("irq_race", 1'b0, irq_n);
    host_u.access(7'h03, 1'b0, 8'h00, rd);
    chk_val("status_kept", 32'h0C, {24'h0, rd});
    // zero fraction and offset: a negative swing must borrow, a positive one must carry
    mode_tgt = 2'h3;
    dev = 9'h1FF;
    for (int i = 0; i < 1600 && st !== RIFC_SEQ_ACTIVE; i++) @(negedge clk_sys_in);
    chk_bit("synth_en", 1'b1, sen);
    for (int k = 0; k < 2; k++) begin
      fsk = k[0];
      ok = 1'b0;
      for (int i = 0; i < 40; i++) begin
        @(negedge clk_sys_in);
        ok |= (sint === 7'd23 + 7'(2 * k));
      end
      chk_bit("fsk_carry", 1'b1, ok);
    end
    chk_val("mode_tx", 32'h3, {30'h0, mact});
    mode_tgt = 2'h0;
    repeat (3) @(negedge clk_sys_in);
    chk_bit("synth_idle", 1'b0, sen);
    chk_val("mode_ready", 32'h0, {30'h0, mact});
    give_verdict();
  end
endmodule // rifc_top_tb_top
